// ### ptpd_analog_decode.sv
// ptpd_analog_decode: turns the analog loop fields into physical settings.
// assumes its outputs are registered by the bank before leaving the block.
`timescale 1ns/10ps
`default_nettype none

module ptpd_analog_decode
  import ptpd_pkg::*;
(
  // stored fields
  ptpd_cfg_if.analog  cfg,
  // decoded loop settings
  output logic [9:0]  cp_current_ua_out,
  output logic [10:0] series_res_ohm_out,
  output logic [7:0]  parallel_cap_pf_out,
  output logic [10:0] post_res_ohm_out,
  output logic [7:0]  post_cap_pf_out,
  output logic [4:0]  lock_accuracy_ppm_out,
  // lock selection
  output logic        lock_auto_out,
  output logic        lock_first_osc_out,
  output logic [4:0]  lock_value_out,
  output logic        synth_only_out
);

  // code n selects (n + 1) steps of 110 uA
  logic [9:0] cp_steps;

  always_comb
  begin
    cp_steps = {7'h00, cfg.fields.charge_pump_current} + 10'h001;
    cp_current_ua_out = 10'(cp_steps * PTPD_CP_STEP_UA); // RQ1
    case (cfg.fields.loop_filter_series_res) // RQ2
      2'h0:    series_res_ohm_out = PTPD_RS_OHM_0;
      2'h1:    series_res_ohm_out = PTPD_RS_OHM_1;
      2'h2:    series_res_ohm_out = PTPD_RS_OHM_2;
      default: series_res_ohm_out = PTPD_RS_OHM_3;
    endcase
    case (cfg.fields.loop_filter_parallel_cap) // RQ3
      2'h0:    parallel_cap_pf_out = PTPD_CP_PF_0;
      2'h1:    parallel_cap_pf_out = PTPD_CP_PF_1;
      2'h2:    parallel_cap_pf_out = PTPD_CP_PF_2;
      default: parallel_cap_pf_out = PTPD_CP_PF_3;
    endcase
    post_res_ohm_out = cfg.fields.second_pole_select ? PTPD_POST_OHM_HIGH
                                                     : PTPD_POST_OHM_LOW; // RQ4
    post_cap_pf_out = PTPD_POST_PF; // RQ4
    lock_accuracy_ppm_out = cfg.fields.lock_count_accuracy ? PTPD_LOCK_PPM_COARSE
                                                           : PTPD_LOCK_PPM_FINE; // RQ5
    lock_auto_out = !cfg.fields.lock_manual_override; // RQ7
    // in automatic mode the selection below is ignored by the loop
    lock_first_osc_out = cfg.fields.manual_oscillator_select; // RQ8
    lock_value_out = cfg.fields.manual_oscillator_select
                   ? cfg.fields.first_osc_lock_value
                   : cfg.fields.second_osc_lock_value; // RQ9
    synth_only_out = cfg.fields.synthesizer_only_mode; // RQ10
  end

endmodule

`default_nettype wire

// ### ptpd_cfg_if.sv
// ptpd_cfg_if: carries the stored fields from the register bank to the
// analog decoder and the power-down controller.
// assumes one writer (the bank) and any number of readers.
`timescale 1ns/10ps
`default_nettype none

interface ptpd_cfg_if;
  import ptpd_pkg::*;
  ptpd_fields_type fields;
  modport bank   (output fields);
  modport analog (input  fields);
  modport power  (input  fields);
endinterface

`default_nettype wire

// ### ptpd_pkg.sv
// ptpd_pkg: offsets, field positions, reset values and decode tables
// for the analog loop tuning and power-down register bank.
// assumes byte-wide registers at 16-bit addresses on the host serial port.

`default_nettype none

package ptpd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [15:0] PTPD_LOOP_FILTER_ADDR  = 16'h00ac;
  localparam logic [15:0] PTPD_LOCK_MODE_ADDR    = 16'h00ad;
  localparam logic [15:0] PTPD_FIRST_VCO_ADDR    = 16'h00ae;
  localparam logic [15:0] PTPD_SECOND_VCO_ADDR   = 16'h00af;
  localparam logic [15:0] PTPD_SPARE_A_ADDR      = 16'h00b4;
  localparam logic [15:0] PTPD_INPUT_REF_ADDR    = 16'h00b5;
  localparam logic [15:0] PTPD_SPARE_B_ADDR      = 16'h00b6;
  localparam logic [15:0] PTPD_OUTPUT_MASK_ADDR  = 16'h00b7;
  localparam logic [15:0] PTPD_CORE_DISABLE_ADDR = 16'h00b8;

  ////////////////////////////////////////////////////////////////////////
  // field positions (low bit of each field)
  localparam int PTPD_CP_CURRENT_POS   = 5;
  localparam int PTPD_SERIES_RES_POS   = 3;
  localparam int PTPD_PARALLEL_CAP_POS = 1;
  localparam int PTPD_SECOND_POLE_POS  = 0;
  localparam int PTPD_SYNTH_MODE_POS   = 3;
  localparam int PTPD_LOCK_COUNT_POS   = 1;
  localparam int PTPD_LOCK_MANUAL_POS  = 0;
  localparam int PTPD_OSC_SELECT_POS   = 5;
  localparam int PTPD_LOCK_VALUE_POS   = 0;
  localparam int PTPD_FIRST_REF_POS    = 0;
  localparam int PTPD_SECOND_REF_POS   = 0;
  localparam int PTPD_DOUBLER_POS      = 0;
  localparam int PTPD_DIGITAL_OFF_POS  = 2;
  localparam int PTPD_CAL_HOLD_POS     = 0;

  // positions shown as fixed ones; they read back as one
  localparam logic [7:0] PTPD_INPUT_REF_ONES   = 8'h06;
  localparam logic [7:0] PTPD_SPARE_B_ONES     = 8'h10;
  localparam logic [7:0] PTPD_CORE_DISABLE_ONES = 8'h0a;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [2:0] PTPD_CP_CURRENT_RST   = 3'h4;
  localparam logic [1:0] PTPD_SERIES_RES_RST   = 2'h1;
  localparam logic [1:0] PTPD_PARALLEL_CAP_RST = 2'h1;
  localparam logic       PTPD_SECOND_POLE_RST  = 1'h1;
  localparam logic       PTPD_LOCK_COUNT_RST   = 1'h1;
  localparam logic       PTPD_LOCK_MANUAL_RST  = 1'h0;
  localparam logic       PTPD_OSC_SELECT_RST   = 1'h1;
  localparam logic [4:0] PTPD_FIRST_LOCK_RST   = 5'h0b;
  localparam logic [4:0] PTPD_SECOND_LOCK_RST  = 5'h00;
  localparam logic       PTPD_SYNTH_MODE_RST   = 1'h0;
  localparam logic       PTPD_DOUBLER_RST      = 1'h0;
  localparam logic [1:0] PTPD_INPUT_OFF_RST    = 2'h0;
  localparam logic [7:0] PTPD_OUTPUT_OFF_RST   = 8'h00;
  localparam logic       PTPD_DIGITAL_OFF_RST  = 1'h0;
  localparam logic       PTPD_CAL_HOLD_RST     = 1'h0;

  ////////////////////////////////////////////////////////////////////////
  // decode tables
  localparam logic [9:0]  PTPD_CP_STEP_UA     = 10'h06e;  // 110 uA
  localparam logic [10:0] PTPD_RS_OHM_0       = 11'h14a;  // 330
  localparam logic [10:0] PTPD_RS_OHM_1       = 11'h280;  // 640
  localparam logic [10:0] PTPD_RS_OHM_2       = 11'h4b0;  // 1200
  localparam logic [10:0] PTPD_RS_OHM_3       = 11'h6fe;  // 1790
  localparam logic [7:0]  PTPD_CP_PF_0        = 8'h28;    // 40
  localparam logic [7:0]  PTPD_CP_PF_1        = 8'h50;    // 80
  localparam logic [7:0]  PTPD_CP_PF_2        = 8'h8c;    // 140
  localparam logic [7:0]  PTPD_CP_PF_3        = 8'hc8;    // 200
  localparam logic [10:0] PTPD_POST_OHM_LOW   = 11'h1f1;  // 497
  localparam logic [10:0] PTPD_POST_OHM_HIGH  = 11'h62c;  // 1580
  localparam logic [7:0]  PTPD_POST_PF        = 8'h28;    // 40
  localparam logic [4:0]  PTPD_LOCK_PPM_FINE  = 5'h01;
  localparam logic [4:0]  PTPD_LOCK_PPM_COARSE = 5'h10;
  localparam logic [1:0]  PTPD_XTAL_DOUBLED   = 2'h2;
  localparam logic [1:0]  PTPD_XTAL_DIRECT    = 2'h1;

  ////////////////////////////////////////////////////////////////////////
  // stored fields
  typedef struct packed {
    logic [2:0] charge_pump_current;
    logic [1:0] loop_filter_series_res;
    logic [1:0] loop_filter_parallel_cap;
    logic       second_pole_select;
    logic       synthesizer_only_mode;
    logic       lock_count_accuracy;
    logic       lock_manual_override;
    logic       manual_oscillator_select;
    logic [4:0] first_osc_lock_value;
    logic [4:0] second_osc_lock_value;
    logic [1:0] input_ref_off;
    logic       crystal_doubler_bypass;
    logic [7:0] output_off;
    logic       digital_loop_off;
    logic       calibration_hold;
  } ptpd_fields_type;

  localparam ptpd_fields_type PTPD_FIELDS_RST = '{
    charge_pump_current:      PTPD_CP_CURRENT_RST,
    loop_filter_series_res:   PTPD_SERIES_RES_RST,
    loop_filter_parallel_cap: PTPD_PARALLEL_CAP_RST,
    second_pole_select:       PTPD_SECOND_POLE_RST,
    synthesizer_only_mode:    PTPD_SYNTH_MODE_RST,
    lock_count_accuracy:      PTPD_LOCK_COUNT_RST,
    lock_manual_override:     PTPD_LOCK_MANUAL_RST,
    manual_oscillator_select: PTPD_OSC_SELECT_RST,
    first_osc_lock_value:     PTPD_FIRST_LOCK_RST,
    second_osc_lock_value:    PTPD_SECOND_LOCK_RST,
    input_ref_off:            PTPD_INPUT_OFF_RST,
    crystal_doubler_bypass:   PTPD_DOUBLER_RST,
    output_off:               PTPD_OUTPUT_OFF_RST,
    digital_loop_off:         PTPD_DIGITAL_OFF_RST,
    calibration_hold:         PTPD_CAL_HOLD_RST
  };

endpackage

`default_nettype wire

// ### ptpd_power_ctrl.sv
// ptpd_power_ctrl: turns the disable fields into run enables.
// assumes its outputs are registered by the bank before leaving the block.
`timescale 1ns/10ps
`default_nettype none

module ptpd_power_ctrl
  import ptpd_pkg::*;
(
  // stored fields
  ptpd_cfg_if.power  cfg,
  // enables
  output logic [1:0] crystal_mult_out,
  output logic [1:0] ref_enable_out,
  output logic [7:0] output_run_out,
  output logic [7:0] output_oe_n_out,
  output logic       digital_loop_run_out,
  output logic       calibration_run_out
);

  always_comb
  begin
    crystal_mult_out = cfg.fields.crystal_doubler_bypass ? PTPD_XTAL_DIRECT
                                                         : PTPD_XTAL_DOUBLED; // RQ12
    ref_enable_out = ~cfg.fields.input_ref_off; // RQ13
    output_run_out = ~cfg.fields.output_off; // RQ14
    // enable is low while driving, so a disabled output floats
    output_oe_n_out = cfg.fields.output_off; // RQ14
    digital_loop_run_out = !cfg.fields.digital_loop_off; // RQ15
    calibration_run_out = !cfg.fields.calibration_hold; // RQ16
  end

endmodule

`default_nettype wire

// ### ptpd_regs.sv
// ptpd_regs: analog loop tuning and power-down register bank, top level.
// assumes the host serial port engine presents single-cycle byte reads
// and writes on the reg_* port, synchronous to clk_in.
//
// How it works
// [RQ1] charge pump code n gives (n+1) x 110 uA, reset code 100
// [RQ2] series resistor code picks 330, 640, 1200 or 1790 ohm, reset 01
// [RQ3] parallel capacitor code picks 40, 80, 140 or 200 pF, reset 01
// [RQ4] second pole bit picks 497 or 1580 ohm, 40 pF, reset one
// [RQ5] lock count bit gives 1 ppm when clear, 16 ppm when set, reset one
// [RQ6] software clears lock count bit above 95 nF loop cap, else sets it
// [RQ7] manual override clear means automatic lock selection, reset clear
// [RQ8] manual mode uses second oscillator when select clear, first when set
// [RQ9] two five-bit manual lock values, reset 01011 and 00000
// [RQ10] synthesizer bit set makes the loop run from crystal only
// [RQ11] software forces digital loop free-run before synthesizer mode
// [RQ12] doubler bypass clear feeds twice crystal frequency, reset clear
// [RQ13] input reference disabled when its bit is set, reset enabled
// [RQ14] output disable bit stops its logic and floats the driver
// [RQ15] digital loop disabled while its bit is set, reset enabled
// [RQ16] analog loop calibration held while its bit is set, reset running
// [RQ17] software writes zero to reserved bits, ignores their read value
// [RQ18] software writes fixed-one positions as one and keeps them
// [RQ19] every field reads back what was written and drives statically
`timescale 1ns/10ps
`default_nettype none

module ptpd_regs
  import ptpd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // register access from the host serial port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output var  logic [7:0]  reg_rdata_out,
  output var  logic        reg_rvalid_out,
  // analog loop settings
  output var  logic [9:0]  cp_current_ua_out,
  output var  logic [10:0] series_res_ohm_out,
  output var  logic [7:0]  parallel_cap_pf_out,
  output var  logic [10:0] post_res_ohm_out,
  output var  logic [7:0]  post_cap_pf_out,
  output var  logic [4:0]  lock_accuracy_ppm_out,
  output var  logic        lock_auto_out,
  output var  logic        lock_first_osc_out,
  output var  logic [4:0]  lock_value_out,
  output var  logic        synth_only_out,
  // power-down controls
  output var  logic [1:0]  crystal_mult_out,
  output var  logic [1:0]  ref_enable_out,
  output var  logic [7:0]  output_run_out,
  output var  logic [7:0]  output_oe_n_out,
  output var  logic        digital_loop_run_out,
  output var  logic        calibration_run_out
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [9:0]  cp_current_ua;
    logic [10:0] series_res_ohm;
    logic [7:0]  parallel_cap_pf;
    logic [10:0] post_res_ohm;
    logic [7:0]  post_cap_pf;
    logic [4:0]  lock_accuracy_ppm;
    logic        lock_auto;
    logic        lock_first_osc;
    logic [4:0]  lock_value;
    logic        synth_only;
  } ptpd_analog_type;

  typedef struct packed {
    logic [1:0] crystal_mult;
    logic [1:0] ref_enable;
    logic [7:0] output_run;
    logic [7:0] output_oe_n;
    logic       digital_loop_run;
    logic       calibration_run;
  } ptpd_power_type;

  typedef struct packed {
    ptpd_fields_type fields;
    ptpd_analog_type analog;
    ptpd_power_type  power;
    logic [7:0]      rdata;
    logic            rvalid;
  } ptpd_state_type;

  ptpd_state_type state_q;
  ptpd_state_type state_d;
  ptpd_analog_type analog_dec;
  ptpd_power_type  power_dec;

  ptpd_cfg_if cfg_bus ();

  assign cfg_bus.fields = state_q.fields;

  ////////////////////////////////////////////////////////////////////////
  // read assembly: reserved bits read zero, fixed-one positions read one

  function automatic logic [7:0] read_byte(input ptpd_fields_type f,
                                           input logic [15:0] addr);
    logic [7:0] b;
    b = 8'h00;
    case (addr)
      PTPD_LOOP_FILTER_ADDR:
      begin
        b[PTPD_CP_CURRENT_POS +: 3]   = f.charge_pump_current;
        b[PTPD_SERIES_RES_POS +: 2]   = f.loop_filter_series_res;
        b[PTPD_PARALLEL_CAP_POS +: 2] = f.loop_filter_parallel_cap;
        b[PTPD_SECOND_POLE_POS]       = f.second_pole_select;
      end
      PTPD_LOCK_MODE_ADDR:
      begin
        b[PTPD_SYNTH_MODE_POS]  = f.synthesizer_only_mode;
        b[PTPD_LOCK_COUNT_POS]  = f.lock_count_accuracy;
        b[PTPD_LOCK_MANUAL_POS] = f.lock_manual_override;
      end
      PTPD_FIRST_VCO_ADDR:
      begin
        b[PTPD_OSC_SELECT_POS]      = f.manual_oscillator_select;
        b[PTPD_LOCK_VALUE_POS +: 5] = f.first_osc_lock_value;
      end
      PTPD_SECOND_VCO_ADDR:
      begin
        b[PTPD_LOCK_VALUE_POS +: 5] = f.second_osc_lock_value;
      end
      PTPD_SPARE_A_ADDR:
      begin
        b[PTPD_FIRST_REF_POS] = f.input_ref_off[0];
      end
      PTPD_INPUT_REF_ADDR:
      begin
        b = PTPD_INPUT_REF_ONES;
        b[PTPD_SECOND_REF_POS] = f.input_ref_off[1];
      end
      PTPD_SPARE_B_ADDR:
      begin
        b = PTPD_SPARE_B_ONES;
        b[PTPD_DOUBLER_POS] = f.crystal_doubler_bypass;
      end
      PTPD_OUTPUT_MASK_ADDR:
      begin
        b = f.output_off;
      end
      PTPD_CORE_DISABLE_ADDR:
      begin
        b = PTPD_CORE_DISABLE_ONES;
        b[PTPD_DIGITAL_OFF_POS] = f.digital_loop_off;
        b[PTPD_CAL_HOLD_POS]    = f.calibration_hold;
      end
      default:
      begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // write decode: only field bits are stored; written reserved and
  // fixed-one bits are dropped, so a careless write cannot upset them

  function automatic ptpd_fields_type write_byte(input ptpd_fields_type f,
                                                 input logic [15:0] addr,
                                                 input logic [7:0] d);
    ptpd_fields_type n;
    n = f;
    case (addr)
      PTPD_LOOP_FILTER_ADDR:
      begin
        n.charge_pump_current      = d[PTPD_CP_CURRENT_POS +: 3];
        n.loop_filter_series_res   = d[PTPD_SERIES_RES_POS +: 2];
        n.loop_filter_parallel_cap = d[PTPD_PARALLEL_CAP_POS +: 2];
        n.second_pole_select       = d[PTPD_SECOND_POLE_POS];
      end
      PTPD_LOCK_MODE_ADDR:
      begin
        // the loop does not check the free-run state itself
        n.synthesizer_only_mode = d[PTPD_SYNTH_MODE_POS]; // RQ11
        n.lock_count_accuracy   = d[PTPD_LOCK_COUNT_POS]; // RQ6
        n.lock_manual_override  = d[PTPD_LOCK_MANUAL_POS];
      end
      PTPD_FIRST_VCO_ADDR:
      begin
        n.manual_oscillator_select = d[PTPD_OSC_SELECT_POS];
        n.first_osc_lock_value     = d[PTPD_LOCK_VALUE_POS +: 5];
      end
      PTPD_SECOND_VCO_ADDR:
      begin
        n.second_osc_lock_value = d[PTPD_LOCK_VALUE_POS +: 5];
      end
      PTPD_SPARE_A_ADDR:
      begin
        n.input_ref_off[0] = d[PTPD_FIRST_REF_POS];
      end
      PTPD_INPUT_REF_ADDR:
      begin
        n.input_ref_off[1] = d[PTPD_SECOND_REF_POS];
      end
      PTPD_SPARE_B_ADDR:
      begin
        n.crystal_doubler_bypass = d[PTPD_DOUBLER_POS];
      end
      PTPD_OUTPUT_MASK_ADDR:
      begin
        n.output_off = d;
      end
      PTPD_CORE_DISABLE_ADDR:
      begin
        n.digital_loop_off = d[PTPD_DIGITAL_OFF_POS];
        n.calibration_hold = d[PTPD_CAL_HOLD_POS];
      end
      default:
      begin
        n = f;
      end
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decoders

  ptpd_analog_decode u_analog (
    .cfg                   (cfg_bus),
    .cp_current_ua_out     (analog_dec.cp_current_ua),
    .series_res_ohm_out    (analog_dec.series_res_ohm),
    .parallel_cap_pf_out   (analog_dec.parallel_cap_pf),
    .post_res_ohm_out      (analog_dec.post_res_ohm),
    .post_cap_pf_out       (analog_dec.post_cap_pf),
    .lock_accuracy_ppm_out (analog_dec.lock_accuracy_ppm),
    .lock_auto_out         (analog_dec.lock_auto),
    .lock_first_osc_out    (analog_dec.lock_first_osc),
    .lock_value_out        (analog_dec.lock_value),
    .synth_only_out        (analog_dec.synth_only)
  );

  ptpd_power_ctrl u_power (
    .cfg                  (cfg_bus),
    .crystal_mult_out     (power_dec.crystal_mult),
    .ref_enable_out       (power_dec.ref_enable),
    .output_run_out       (power_dec.output_run),
    .output_oe_n_out      (power_dec.output_oe_n),
    .digital_loop_run_out (power_dec.digital_loop_run),
    .calibration_run_out  (power_dec.calibration_run)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    state_d = state_q;
    if (reg_wr_in)
    begin
      state_d.fields = write_byte(state_q.fields, reg_addr_in, reg_wdata_in); // RQ19
    end
    // settings follow stored fields one cycle later and then hold
    state_d.analog = analog_dec; // RQ19
    state_d.power  = power_dec; // RQ19
    state_d.rvalid = reg_rd_in;
    // a read in the same cycle as a write returns the old contents
    state_d.rdata  = reg_rd_in ? read_byte(state_q.fields, reg_addr_in)
                               : state_q.rdata; // RQ19
  end

  // reset image of the decoded settings, matching the reset fields
  localparam ptpd_analog_type ANALOG_RST = '{
    cp_current_ua:     10'(({7'h00, PTPD_CP_CURRENT_RST} + 10'h001) * PTPD_CP_STEP_UA),
    series_res_ohm:    PTPD_RS_OHM_1,
    parallel_cap_pf:   PTPD_CP_PF_1,
    post_res_ohm:      PTPD_POST_OHM_HIGH,
    post_cap_pf:       PTPD_POST_PF,
    lock_accuracy_ppm: PTPD_LOCK_PPM_COARSE,
    lock_auto:         1'h1,
    lock_first_osc:    PTPD_OSC_SELECT_RST,
    lock_value:        PTPD_FIRST_LOCK_RST,
    synth_only:        PTPD_SYNTH_MODE_RST
  };

  localparam ptpd_power_type POWER_RST = '{
    crystal_mult:     PTPD_XTAL_DOUBLED,
    ref_enable:       2'h3,
    output_run:       8'hff,
    output_oe_n:      8'h00,
    digital_loop_run: 1'h1,
    calibration_run:  1'h1
  };

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q.fields <= PTPD_FIELDS_RST;
      state_q.analog <= ANALOG_RST;
      state_q.power  <= POWER_RST;
      state_q.rdata  <= 8'h00;
      state_q.rvalid <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out         = state_q.rdata;
  assign reg_rvalid_out        = state_q.rvalid;
  assign cp_current_ua_out     = state_q.analog.cp_current_ua;
  assign series_res_ohm_out    = state_q.analog.series_res_ohm;
  assign parallel_cap_pf_out   = state_q.analog.parallel_cap_pf;
  assign post_res_ohm_out      = state_q.analog.post_res_ohm;
  assign post_cap_pf_out       = state_q.analog.post_cap_pf;
  assign lock_accuracy_ppm_out = state_q.analog.lock_accuracy_ppm;
  assign lock_auto_out         = state_q.analog.lock_auto;
  assign lock_first_osc_out    = state_q.analog.lock_first_osc;
  assign lock_value_out        = state_q.analog.lock_value;
  assign synth_only_out        = state_q.analog.synth_only;
  assign crystal_mult_out      = state_q.power.crystal_mult;
  assign ref_enable_out        = state_q.power.ref_enable;
  assign output_run_out        = state_q.power.output_run;
  assign output_oe_n_out       = state_q.power.output_oe_n;
  assign digital_loop_run_out  = state_q.power.digital_loop_run;
  assign calibration_run_out   = state_q.power.calibration_run;

endmodule

`default_nettype wire

// ### ptpd_regs_chk.sv
// ptpd_regs_chk: port checks for the loop tuning and power-down bank.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ptpd_regs_chk
(
  // clock, reset and register port
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_rvalid_out,
  // watched controls
  input wire logic [9:0]  cp_current_ua_out,
  input wire logic [7:0]  post_cap_pf_out,
  input wire logic [7:0]  output_run_out,
  input wire logic [7:0]  output_oe_n_out,
  input wire logic        digital_loop_run_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////
  // a write is stored at its edge and decoded one edge later
  sequence s_wr(a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  property p_cp;
    logic [2:0] c;
    (s_wr(16'h00ac), c = reg_wdata_in[7:5]) |=> ##1
      cp_current_ua_out == 10'h06e * (10'(c) + 10'h001);
  endproperty
  property p_off;
    logic [7:0] m;
    (s_wr(16'h00b7), m = reg_wdata_in) |=> ##1 output_run_out == ~m;
  endproperty
  property p_dl;
    logic b;
    (s_wr(16'h00b8), b = reg_wdata_in[2]) |=> ##1 digital_loop_run_out != b;
  endproperty
  ////////////////////////////////////////////////////////////////////////
  chk_cp_decode: assert property (p_cp) else $error("cp decode");
  chk_output_off: assert property (p_off) else $error("output off");
  chk_digital_off: assert property (p_dl) else $error("digital off");
  chk_oe_follows: assert property (output_oe_n_out == ~output_run_out)
    else $error("oe mismatch");
  chk_post_cap: assert property (post_cap_pf_out == 8'h28) else $error("post cap");
  // without a write the output run, charge pump and digital loop controls may not move: they are static levels
  chk_static_hold: assert property (!reg_wr_in |=> ##1 $stable(output_run_out)
    && $stable(cp_current_ua_out) && $stable(digital_loop_run_out)) else $error("drift");
  chk_read_pulse: assert property (reg_rd_in |=> reg_rvalid_out) else $error("no rvalid");
  chk_read_quiet: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("rvalid");
endmodule
bind ptpd_regs ptpd_regs_chk u_chk (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
  .reg_rd_in, .reg_wdata_in, .reg_rvalid_out, .cp_current_ua_out, .post_cap_pf_out,
  .output_run_out, .output_oe_n_out, .digital_loop_run_out);
`default_nettype wire

// ### tb_ptpd_regs.sv
// tb_ptpd_regs: corner and random register traffic, readback, decoded outputs.
// assumes single-cycle strobes on the reg_* byte port.
`timescale 1ns/10ps
`default_nettype none
module tb_ptpd_regs;
  logic        clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [15:0] reg_addr_in = 0;
  logic [7:0]  reg_wdata_in = 0, reg_rdata_out, parallel_cap_pf_out, post_cap_pf_out, d;
  logic [7:0]  output_run_out, output_oe_n_out;
  logic [9:0]  cp_current_ua_out;
  logic [10:0] series_res_ohm_out, post_res_ohm_out;
  logic [4:0]  lock_accuracy_ppm_out, lock_value_out;
  logic [1:0]  crystal_mult_out, ref_enable_out;
  logic        reg_rvalid_out, lock_auto_out, lock_first_osc_out, synth_only_out;
  logic        digital_loop_run_out, calibration_run_out;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  // slot 9 is unmapped; fixed ones are the reset bits outside the write mask
  logic [7:0]  ad [10] = '{8'hac, 8'had, 8'hae, 8'haf, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb0};
  logic [7:0]  rv [10] = '{8'h8b, 8'h02, 8'h2b, 8'h00, 8'h00, 8'h06, 8'h10, 8'h00, 8'h0a, 8'h00};
  logic [7:0]  wm [10] = '{8'hff, 8'h0b, 8'h3f, 8'h1f, 8'h01, 8'h01, 8'h01, 8'hff, 8'h05, 8'h00};
  logic [7:0]  sh [10];
  logic [10:0] rs [4] = '{11'h14a, 11'h280, 11'h4b0, 11'h6fe};
  logic [7:0]  pf [4] = '{8'h28, 8'h50, 8'h8c, 8'hc8};
  ptpd_regs dut (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
    .reg_rdata_out, .reg_rvalid_out, .cp_current_ua_out, .series_res_ohm_out,
    .parallel_cap_pf_out, .post_res_ohm_out, .post_cap_pf_out, .lock_accuracy_ppm_out,
    .lock_auto_out, .lock_first_osc_out, .lock_value_out, .synth_only_out, .crystal_mult_out,
    .ref_enable_out, .output_run_out, .output_oe_n_out, .digital_loop_run_out,
    .calibration_run_out);
  always #10 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      complete_run();
    end
  end
  // strobe stays high so consecutive calls give back-to-back writes
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_in);
    reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = v;
  endtask
  task automatic rd_all();
    for (int i = 0; i <= 10; i++)
    begin
      @(negedge clk_in);
      if (i > 0)
        chk({reg_rvalid_out, reg_rdata_out}, {1'b1, sh[i-1]});
      reg_rd_in = (i < 10);
      reg_addr_in = {8'h00, ad[i % 10]};
    end
  endtask
  task automatic chk_outs();
    chk({cp_current_ua_out, series_res_ohm_out, parallel_cap_pf_out, post_res_ohm_out},
      {10'h06e * (10'(sh[0][7:5]) + 10'h001), rs[sh[0][4:3]], pf[sh[0][2:1]],
      sh[0][0] ? 11'h62c : 11'h1f1});
    chk({post_cap_pf_out, lock_accuracy_ppm_out, lock_auto_out, lock_first_osc_out,
      lock_value_out, synth_only_out}, {8'h28, sh[1][1] ? 5'h10 : 5'h01, ~sh[1][0],
      sh[2][5], sh[2][5] ? sh[2][4:0] : sh[3][4:0], sh[1][3]});
    chk({crystal_mult_out, ref_enable_out, output_run_out, output_oe_n_out,
      digital_loop_run_out, calibration_run_out}, {sh[6][0] ? 2'h1 : 2'h2, ~sh[5][0],
      ~sh[4][0], ~sh[7], sh[7], ~sh[8][2], ~sh[8][0]});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // round 0 reset state, 1 all ones, 2 all zeros, then random, charge pump code r[2:0] in rounds 1 to 10, 11 reset again
  initial
  begin
    void'($urandom(32'h8675));
    sh = rv;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1;
    for (int r = 0; r < 12; r++)
    begin
      for (int i = 0; i < 10 && r % 11 != 0; i++)
      begin
        d = (r == 1 ? 8'hff : r == 2 ? 8'h00 : 8'($urandom)) & wm[i] | rv[i] & ~wm[i];
        if (i == 0)
          d[7:5] = r[2:0];
        wr({8'h00, ad[i]}, i < 9 ? d : 8'($urandom));
        if (i < 9)
          sh[i] = d;
      end
      @(negedge clk_in);
      reg_wr_in = 0;
      rst_n_in = (r != 11);
      repeat (2) @(negedge clk_in);
      rst_n_in = 1;
      if (r == 11)
        sh = rv;
      chk_outs();
      rd_all();
      $display("test %0d done", r);
    end
    complete_run();
  end
endmodule
`default_nettype wire
